// file: rtl/module_mgmt_defines.vh
`ifndef MODULE_MGMT_DEFINES_VH
`define MODULE_MGMT_DEFINES_VH

// ---------------------------------------------------------------
// Register bus map
// ---------------------------------------------------------------
`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define EVENT_ADDR 8'h08
`define CTRL_RESET 32'h0000_0000
`define CTRL_FORCE_LP_BIT 0
`define STAT_SELECTED_BIT 0
`define STAT_LP_PIN_BIT 1
`define STAT_LP_ACTIVE_BIT 2
`define STAT_INTR_BIT 3
`define STAT_PAGE_LSB 8
`define STAT_BANK_LSB 16
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// ---------------------------------------------------------------
// Management memory layout
// ---------------------------------------------------------------
`define MGMT_DEV_ADDR 7'h50
`define FLAG_OFFSET 8'h08
`define BANK_SEL_OFFSET 8'h7E
`define PAGE_SEL_OFFSET 8'h7F
`define PAGE_00 8'h00
`define PAGE_01 8'h01
`define PAGE_02 8'h02
`define PAGE_10 8'h10
`define PAGE_11 8'h11
`define BANK_0 8'h00
`define MEM_WORDS 768
`define UNMAPPED_BYTE 8'h00
`define FLAG_LP_BIT 0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define RESET_INIT_NS 10000
`define RESET_INIT_CYC 9'h0fa

`endif

// file: rtl/module_mgmt.v
`timescale 1ns/10ps
`include "module_mgmt_defines.vh"

module module_mgmt (
   input wire core_clk,
   input wire reset_n,
   input wire module_select_n,
   input wire module_reset_n,
   input wire low_power_request_in,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   output wire interrupt_out_n_out,
   output wire interrupt_out_n_oe,
   output wire module_present_n,
   output wire low_power_active,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);

   localparam ST_IDLE = 3'd0;
   localparam ST_RX = 3'd1;
   localparam ST_ACK = 3'd2;
   localparam ST_TX = 3'd3;
   localparam ST_RACK = 3'd4;
   localparam KIND_ADDR = 2'd0;
   localparam KIND_OFFSET = 2'd1;
   localparam KIND_DATA = 2'd2;
   localparam [8:0] RESET_CYC = `RESET_INIT_CYC;

   // Maps host offset plus page and bank to an array slot; bit 10 = valid
   function [10:0] map_index;
      input [7:0] off;
      input [7:0] pg;
      input [7:0] bk;
      reg [2:0] slot;
      begin
         slot = 3'd7;
         if (!off[7])
            slot = 3'd0;
         else if (pg == `PAGE_00)
            slot = 3'd1;
         else if (pg == `PAGE_01)
            slot = 3'd2;
         else if (pg == `PAGE_02)
            slot = 3'd3;
         else if (pg == `PAGE_10 && bk == `BANK_0)
            slot = 3'd4;
         else if (pg == `PAGE_11 && bk == `BANK_0)
            slot = 3'd5;
         map_index = {(slot != 3'd7), slot[2:0], off[6:0]};
      end
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg scl_d_reg;
   reg sda_d_reg;

   // Pins come from the host domain; second stage only is read
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 5'b0_1111; // Power pin idles low: no false change
         sync2_reg <= 5'b0_1111;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         sync1_reg <= {low_power_request_in, module_reset_n,
                       module_select_n, sda_in, scl_in};
         sync2_reg <= sync1_reg;
         scl_d_reg <= sync2_reg[0];
         sda_d_reg <= sync2_reg[1];
      end
   end

   wire scl_s = sync2_reg[0];
   wire sda_s = sync2_reg[1];
   wire selected = ~sync2_reg[2];
   wire mrst_s = sync2_reg[3];
   wire lp_pin_s = sync2_reg[4];
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ---------------------------------------------------------------
   // Module reset pin qualification
   // ---------------------------------------------------------------
   reg [8:0] mrst_cnt_reg;
   reg user_rst_reg;

   // Pulse length check
   // Short glitches on the pin never reach the settings
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mrst_cnt_reg <= 9'h000;
         user_rst_reg <= 1'b0;
      end else if (mrst_s) begin
         mrst_cnt_reg <= 9'h000;
         user_rst_reg <= 1'b0;
      end else if (mrst_cnt_reg >= RESET_CYC) begin
         user_rst_reg <= 1'b1;
      end else begin
         mrst_cnt_reg <= mrst_cnt_reg + 9'd1;
      end
   end

   // ---------------------------------------------------------------
   // Management memory
   // ---------------------------------------------------------------
   reg [7:0] mem [0:`MEM_WORDS-1];
   reg mem_we_reg;
   reg [9:0] mem_wa_reg;
   reg [7:0] mem_wd_reg;
   reg [7:0] page_reg;
   reg [7:0] bank_reg;
   reg [7:0] act_page_reg;
   reg [7:0] act_bank_reg;
   reg [7:0] offset_reg;
   reg [7:0] flags_reg;

   // Array has no reset so it maps onto plain RAM
   always @(posedge core_clk) begin
      if (mem_we_reg)
         mem[mem_wa_reg] <= mem_wd_reg;
   end

   // Fixed lower half, paged upper half
   wire [10:0] rd_map = map_index(offset_reg, act_page_reg, act_bank_reg);
   reg [7:0] rd_byte;

   // Read data mux; select bytes and flags live outside the array
   always @* begin
      if (offset_reg == `PAGE_SEL_OFFSET)
         rd_byte = page_reg;
      else if (offset_reg == `BANK_SEL_OFFSET)
         rd_byte = bank_reg;
      else if (offset_reg == `FLAG_OFFSET)
         rd_byte = flags_reg;
      else if (!rd_map[10])
         rd_byte = `UNMAPPED_BYTE;
      else
         rd_byte = mem[rd_map[9:0]];
   end

   // ---------------------------------------------------------------
   // Two-wire serial slave
   // ---------------------------------------------------------------
   reg [2:0] state_reg;
   reg [2:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [1:0] kind_reg;
   reg rw_reg;
   reg ack_pend_reg;
   reg sda_oe_reg;
   reg [7:0] flag_clr_reg;

   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};

   // Byte engine, paced by scl edges seen on core_clk
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'd0;
         shift_reg <= 8'h00;
         kind_reg <= KIND_ADDR;
         rw_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         offset_reg <= 8'h00;
         page_reg <= 8'h00;
         bank_reg <= 8'h00;
         act_page_reg <= 8'h00;
         act_bank_reg <= 8'h00;
         mem_we_reg <= 1'b0;
         mem_wa_reg <= 10'h000;
         mem_wd_reg <= 8'h00;
         flag_clr_reg <= 8'h00;
      end else begin
         mem_we_reg <= 1'b0;
         flag_clr_reg <= 8'h00;
         if (user_rst_reg) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            offset_reg <= 8'h00;
            page_reg <= 8'h00;
            bank_reg <= 8'h00;
            act_page_reg <= 8'h00;
            act_bank_reg <= 8'h00;
         end else if (!selected) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
         end else if (bus_start) begin
            state_reg <= ST_RX;
            kind_reg <= KIND_ADDR;
            bit_cnt_reg <= 3'd0;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            act_page_reg <= page_reg;
            act_bank_reg <= bank_reg;
         end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_RX: begin
                  if (scl_rise) begin
                     shift_reg <= rx_byte;
                     bit_cnt_reg <= bit_cnt_reg + 3'd1;
                  end
                  if (scl_rise && bit_cnt_reg == 3'd7) begin
                     ack_pend_reg <= 1'b1;
                     if (kind_reg == KIND_ADDR) begin
                        rw_reg <= rx_byte[0];
                        if (rx_byte[7:1] != `MGMT_DEV_ADDR) begin
                           ack_pend_reg <= 1'b0;
                           state_reg <= ST_IDLE;
                        end
                     end else if (kind_reg == KIND_OFFSET) begin
                        offset_reg <= rx_byte;
                     end else begin
                        offset_reg <= offset_reg + 8'd1;
                        if (offset_reg == `PAGE_SEL_OFFSET)
                           page_reg <= rx_byte;
                        else if (offset_reg == `BANK_SEL_OFFSET)
                           bank_reg <= rx_byte;
                        else if (rd_map[10] &&
                                 offset_reg != `FLAG_OFFSET) begin
                           mem_we_reg <= 1'b1;
                           mem_wa_reg <= rd_map[9:0];
                           mem_wd_reg <= rx_byte;
                        end
                     end
                  end else if (scl_fall && ack_pend_reg) begin
                     ack_pend_reg <= 1'b0;
                     sda_oe_reg <= 1'b1;
                     state_reg <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 3'd0;
                     if (kind_reg == KIND_ADDR && rw_reg) begin
                        state_reg <= ST_TX;
                        shift_reg <= rd_byte;
                        sda_oe_reg <= ~rd_byte[7];
                        offset_reg <= offset_reg + 8'd1;
                        if (offset_reg == `FLAG_OFFSET)
                           flag_clr_reg <= rd_byte;
                     end else begin
                        state_reg <= ST_RX;
                        sda_oe_reg <= 1'b0;
                        if (kind_reg == KIND_ADDR)
                           kind_reg <= KIND_OFFSET;
                        else
                           kind_reg <= KIND_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 3'd7) begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_RACK;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= ~shift_reg[6];
                     end
                  end
               end
               ST_RACK: begin
                  // Host NACK ends the read; wait for stop or start
                  if (scl_rise) begin
                     if (sda_s)
                        state_reg <= ST_IDLE;
                     else
                        ack_pend_reg <= 1'b1;
                  end else if (scl_fall && ack_pend_reg) begin
                     ack_pend_reg <= 1'b0;
                     state_reg <= ST_TX;
                     bit_cnt_reg <= 3'd0;
                     shift_reg <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                     offset_reg <= offset_reg + 8'd1;
                     if (offset_reg == `FLAG_OFFSET)
                        flag_clr_reg <= rd_byte;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  sda_oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg;

   // ---------------------------------------------------------------
   // Register bus, power mode and flags
   // ---------------------------------------------------------------
   reg [31:0] ctrl_reg;
   reg lp_active_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;

   wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire event_wr = do_write && aw_addr_reg == `EVENT_ADDR && w_strb_reg[0];
   wire [7:0] event_set = event_wr ? {w_data_reg[7:1], 1'b0} : 8'h00;
   wire lp_next = lp_pin_s | ctrl_reg[`CTRL_FORCE_LP_BIT];
   wire lp_change = lp_next ^ lp_active_reg;

   // Flags set by events; set wins over a same-cycle read clear
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lp_active_reg <= 1'b0;
         flags_reg <= 8'h00;
      end else begin
         lp_active_reg <= lp_next;
         if (user_rst_reg)
            flags_reg <= 8'h00;
         else
            flags_reg <= (flags_reg & ~flag_clr_reg) | event_set |
                         {7'h00, lp_change};
      end
   end

   assign interrupt_out_n_out = 1'b0;
   assign interrupt_out_n_oe = |flags_reg;
   assign module_present_n = 1'b0;
   assign low_power_active = lp_active_reg;

   // Write channel: address and data taken in either order
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
         ctrl_reg <= `CTRL_RESET;
      end else begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= `RESP_OKAY;
            if (aw_addr_reg == `CTRL_ADDR) begin
               if (w_strb_reg[0])
                  ctrl_reg[7:0] <= w_data_reg[7:0];
            end else if (aw_addr_reg != `EVENT_ADDR &&
                         aw_addr_reg != `STATUS_ADDR)
               bresp_reg <= `RESP_DECERR;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
         if (user_rst_reg)
            ctrl_reg <= `CTRL_RESET;
      end
   end

   // Read channel: one cycle from address to data
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         case (s_axi_araddr)
            `CTRL_ADDR: rdata_reg <= ctrl_reg;
            `STATUS_ADDR: begin
               rdata_reg[`STAT_SELECTED_BIT] <= selected;
               rdata_reg[`STAT_LP_PIN_BIT] <= lp_pin_s;
               rdata_reg[`STAT_LP_ACTIVE_BIT] <= lp_active_reg;
               rdata_reg[`STAT_INTR_BIT] <= |flags_reg;
               rdata_reg[`STAT_PAGE_LSB+7:`STAT_PAGE_LSB] <= page_reg;
               rdata_reg[`STAT_BANK_LSB+7:`STAT_BANK_LSB] <= bank_reg;
            end
            `EVENT_ADDR: rdata_reg[7:0] <= flags_reg;
            default: rresp_reg <= `RESP_DECERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready = ~w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

endmodule

// file: tb/mgmt_checker.sv
`timescale 1ns/10ps
module mgmt_checker (
   input wire core_clk,
   input wire reset_n,
   input wire module_select_n,
   input wire module_reset_n,
   input wire low_power_request_in,
   input wire scl_in,
   input wire sda_oe,
   input wire interrupt_out_n_out,
   input wire interrupt_out_n_oe,
   input wire module_present_n,
   input wire low_power_active
);
   reg [9:0] rst_cnt;
   // Low time of the module reset pin
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         rst_cnt <= 10'h000;
      else if (module_reset_n)
         rst_cnt <= 10'h000;
      else if (rst_cnt != 10'h3ff)
         rst_cnt <= rst_cnt + 10'h001;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   presence_low_a: assert property (
      module_present_n == 1'b0) else $error("presence pin not low");
   intr_low_only_a: assert property (
      interrupt_out_n_out == 1'b0) else $error("interrupt driven high");
   // Allows two sync flops and the output register
   desel_quiet_a: assert property (
      module_select_n [*5] |-> !sda_oe) else $error("deselected drive");
   lp_pin_a: assert property (
      low_power_request_in [*5] |-> low_power_active)
      else $error("low power pin ignored");
   ack_scl_low_a: assert property (
      $changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
   change_flag_a: assert property (
      $changed(low_power_active) && module_reset_n |-> ##[0:3]
      interrupt_out_n_oe) else $error("no interrupt on mode change");
   // No serial read can clear the flags while deselected
   hold_intr_a: assert property (
      module_select_n && module_reset_n && interrupt_out_n_oe |=>
      interrupt_out_n_oe) else $error("interrupt released unread");
   reset_clear_a: assert property (
      rst_cnt > 10'h104 |-> !interrupt_out_n_oe)
      else $error("flags survive reset");
   cover property ($rose(sda_oe));
   cover property ($rose(interrupt_out_n_oe));
   cover property ($rose(low_power_active));
   cover property (rst_cnt == 10'h105);
endmodule
bind module_mgmt mgmt_checker mgmt_checker_inst (.*);

// file: tb/host_link.sv
`timescale 1ns/10ps
module host_link (
   output reg scl_line,
   output reg sda_pull,
   input wire sda_wire
);
   // Quarter of the 320 ns link clock period
   localparam integer Q = 80;
   // Idle bus: clock stands high, data left to the pull-up
   initial begin
      scl_line = 1'b1;
      sda_pull = 1'b0;
   end
   // One pulse: data set mid-low, sampled mid-high
   task clock_bit(input pull, output seen);
      begin
         #Q sda_pull = pull;
         #Q scl_line = 1'b1;
         #Q seen = sda_wire;
         #Q scl_line = 1'b0;
      end
   endtask
   task put_start;
      begin
         #(Q + 10) sda_pull = 1'b0; // Off the core clock edges
         #Q scl_line = 1'b1;
         #Q sda_pull = 1'b1;
         #Q scl_line = 1'b0;
      end
   endtask
   // Stop leaves the clock parked high between frames
   task put_stop;
      begin
         #Q sda_pull = 1'b1;
         #Q scl_line = 1'b1;
         #Q sda_pull = 1'b0;
         #Q;
      end
   endtask
   task put_byte(input [7:0] v, output ok);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            clock_bit(~v[i], ok);
         clock_bit(1'b0, ok);
         ok = ~ok;
      end
   endtask
   // Host acknowledges every byte but the last
   task get_byte(output [7:0] v, input last);
      integer i;
      reg s;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            clock_bit(1'b0, s);
            v[i] = s;
         end
         clock_bit(~last, s);
      end
   endtask
endmodule

// file: tb/module_mgmt_control_paged_memory_tb.sv
`timescale 1ns/10ps
`include "module_mgmt_defines.vh"
module module_mgmt_control_paged_memory_tb;
   // Select settle times are free choices here
   localparam integer SEL_WAIT_CYC = 16;
   reg core_clk, reset_n, module_select_n, module_reset_n;
   reg low_power_request_in;
   reg [7:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg [3:0] s_axi_wstrb;
   reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   reg s_axi_rready;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, sda_out, sda_oe, interrupt_out_n_out;
   wire interrupt_out_n_oe, module_present_n, low_power_active;
   wire scl_line, sda_pull;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   // Open-drain lines resolved against their pull-ups
   wire sda_line = !((sda_oe && !sda_out) || sda_pull);
   wire int_line = !(interrupt_out_n_oe && !interrupt_out_n_out);
   integer err_total, n_checks;
   reg [31:0] d;
   reg [1:0] r;
   reg [7:0] b;
   reg k;
   module_mgmt module_mgmt_inst (.core_clk, .reset_n, .module_select_n,
      .module_reset_n, .low_power_request_in, .scl_in(scl_line),
      .sda_in(sda_line), .sda_out, .sda_oe, .interrupt_out_n_out,
      .interrupt_out_n_oe, .module_present_n, .low_power_active,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   host_link host_link_inst (.scl_line, .sda_pull, .sda_wire(sda_line));
   task chk(input string what, input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task end_sim;
      begin
         if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Each channel drops its valid at its own handshake edge
   task axi_wr(input [7:0] a, input [31:0] wd, output [1:0] rs);
      begin
         @(posedge core_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= wd;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         @(posedge core_clk);
         while (!s_axi_bvalid) begin
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
            @(posedge core_clk);
         end
         rs = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task axi_rd(input [7:0] a, output [31:0] rd, output [1:0] rs);
      begin
         @(posedge core_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         @(posedge core_clk);
         while (!s_axi_rvalid) begin
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
            @(posedge core_clk);
         end
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task ser_wr(input [7:0] o, input [7:0] v);
      reg k1, k2, k3;
      begin
         host_link_inst.put_start;
         host_link_inst.put_byte(8'ha0, k1);
         host_link_inst.put_byte(o, k2);
         host_link_inst.put_byte(v, k3);
         host_link_inst.put_stop;
         chk("write acks", {k1, k2, k3}, 3'h7);
      end
   endtask
   task ser_rd(input [7:0] o, output [7:0] v);
      reg k1, k2, k3;
      begin
         host_link_inst.put_start;
         host_link_inst.put_byte(8'ha0, k1);
         host_link_inst.put_byte(o, k2);
         host_link_inst.put_start;
         host_link_inst.put_byte(8'ha1, k3);
         host_link_inst.get_byte(v, 1'b1);
         host_link_inst.put_stop;
         chk("read acks", {k1, k2, k3}, 3'h7);
      end
   endtask
   task t_pins;
      integer v;
      begin
         chk("present", module_present_n, 1'b0);
         ser_rd(`FLAG_OFFSET, b);
         for (v = 1; v >= 0; v = v - 1) begin
            @(posedge core_clk);
            low_power_request_in <= v[0];
            repeat (8) @(posedge core_clk);
            chk("lp active", low_power_active, v[0]);
            chk("int set", int_line, 1'b0);
            ser_rd(`FLAG_OFFSET, b);
            chk("flag", b, 8'h01);
            chk("int clear", int_line, 1'b1);
         end
      end
   endtask
   task t_regs;
      begin
         axi_rd(`CTRL_ADDR, d, r);
         chk("ctrl reset", d, `CTRL_RESET);
         axi_wr(`CTRL_ADDR, 32'h0000_0001, r);
         repeat (4) @(posedge core_clk);
         chk("forced lp", low_power_active, 1'b1);
         axi_wr(`CTRL_ADDR, 32'h0000_0000, r);
         ser_rd(`FLAG_OFFSET, b);
         chk("mode flag", b, 8'h01);
         axi_wr(`EVENT_ADDR, 32'h0000_0007, r);
         axi_rd(`EVENT_ADDR, d, r);
         chk("event", d[7:0], 8'h06);
         axi_rd(8'h0c, d, r);
         chk("unmapped", r, `RESP_DECERR);
         axi_wr(`STATUS_ADDR, 32'hffff_ffff, r);
         chk("status wr", r, `RESP_OKAY);
         ser_rd(`FLAG_OFFSET, b);
         chk("event flag", b, 8'h06);
         chk("int clear", int_line, 1'b1);
      end
   endtask
   // Pages written in turn, then read back across switches
   task t_paging;
      begin
         ser_wr(8'h20, 8'h5a);
         ser_wr(`PAGE_SEL_OFFSET, `PAGE_01);
         ser_wr(8'h80, 8'ha5);
         ser_wr(`PAGE_SEL_OFFSET, `PAGE_02);
         ser_wr(8'h80, 8'h3c);
         ser_rd(8'h20, b);
         chk("lower", b, 8'h5a);
         ser_rd(8'h80, b);
         chk("page 2", b, 8'h3c);
         ser_wr(`PAGE_SEL_OFFSET, `PAGE_01);
         ser_rd(8'h80, b);
         chk("page 1", b, 8'ha5);
         ser_wr(`PAGE_SEL_OFFSET, `PAGE_10);
         ser_wr(8'h90, 8'h77);
         ser_wr(`BANK_SEL_OFFSET, 8'h01);
         ser_wr(8'h90, 8'hee);
         ser_rd(8'h90, b);
         chk("bank 1", b, `UNMAPPED_BYTE);
         axi_rd(`STATUS_ADDR, d, r);
         chk("page bank", d[23:8], 16'h0110);
         ser_wr(`BANK_SEL_OFFSET, `BANK_0);
         ser_rd(8'h90, b);
         chk("bank 0", b, 8'h77);
         ser_wr(`PAGE_SEL_OFFSET, 8'h20);
         ser_rd(8'hff, b);
         chk("absent page", b, `UNMAPPED_BYTE);
      end
   endtask
   task t_desel;
      begin
         axi_wr(`EVENT_ADDR, 32'h0000_0080, r);
         @(posedge core_clk);
         module_select_n <= 1'b1;
         repeat (SEL_WAIT_CYC) @(posedge core_clk);
         host_link_inst.put_start;
         host_link_inst.put_byte(8'ha1, k);
         host_link_inst.put_stop;
         chk("no ack", k, 1'b0);
         chk("int held", int_line, 1'b0);
         @(posedge core_clk);
         module_select_n <= 1'b0;
         repeat (SEL_WAIT_CYC) @(posedge core_clk);
         ser_rd(`FLAG_OFFSET, b);
         chk("flag 7", b, 8'h80);
         chk("int clear", int_line, 1'b1);
      end
   endtask
   task t_modreset;
      begin
         axi_wr(`CTRL_ADDR, 32'h0000_0001, r);
         ser_wr(`PAGE_SEL_OFFSET, `PAGE_01);
         @(posedge core_clk);
         module_reset_n <= 1'b0;
         repeat (`RESET_INIT_CYC + 50) @(posedge core_clk);
         module_reset_n <= 1'b1;
         repeat (6) @(posedge core_clk);
         chk("lp default", low_power_active, 1'b0);
         axi_rd(`CTRL_ADDR, d, r);
         chk("ctrl default", d, `CTRL_RESET);
         axi_rd(`STATUS_ADDR, d, r);
         chk("page default", d[15:8], `PAGE_00);
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // A run takes about 0.3 ms; nearly seven times that means a hang
   initial begin
      #2000000;
      err_total = err_total + 1;
      end_sim;
   end
   initial begin
      err_total = 0;
      n_checks = 0;
      reset_n = 1'b0;
      module_select_n = 1'b0;
      module_reset_n = 1'b1;
      low_power_request_in = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_pins;
      t_regs;
      t_paging;
      t_desel;
      t_modreset;
      end_sim;
   end
endmodule
